// >>> core/pasr_mgmt_ctrl.sv
module pasr_mgmt_ctrl
   import pasr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [2:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   pasr_if.host             mgmt
);
   logic              busy_r;
   logic              we_r;
   logic [4:0]        addr_r;
   logic [15:0]       wdata_r;
   logic [15:0]       rdata_r;
   logic              done_r;
   logic              avs_ack_r;
   logic [31:0]       rd_r;

   // One-cycle answer: waitrequest drops in the cycle after the request
   assign avs_waitrequest = (avs_read || avs_write) && !avs_ack_r;

   always_ff @(posedge clk) begin
      if (rst)
         avs_ack_r <= 1'b0;
      else
         avs_ack_r <= (avs_read || avs_write) && !avs_ack_r;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rd_r <= 32'h0000_0000;
      end else if (avs_read && !avs_ack_r) begin
         case (avs_address)
            PASR_C_CMD:    rd_r <= {busy_r, 22'h00_0000, we_r, 3'h0, addr_r};
            PASR_C_WDATA:  rd_r <= {16'h0000, wdata_r};
            PASR_C_RDATA:  rd_r <= {16'h0000, rdata_r};
            PASR_C_STATUS: rd_r <= {30'h0000_0000, done_r, busy_r};
            default:       rd_r <= 32'h0000_0000;
         endcase
      end
   end
   assign avs_readdata = rd_r;

   // Command start; relies on the device ignoring read-only bits
   always_ff @(posedge clk) begin
      if (rst) begin
         busy_r  <= 1'b0;
         we_r    <= 1'b0;
         addr_r  <= 5'h00;
         wdata_r <= 16'h0000;
         rdata_r <= 16'h0000;
         done_r  <= 1'b0;
      end else begin
         if (busy_r && mgmt.ack) begin
            busy_r <= 1'b0;
            done_r <= 1'b1;
            if (!we_r)
               rdata_r <= mgmt.rdata;
         end else if (avs_write && !avs_ack_r && !busy_r) begin
            if (avs_address == PASR_C_WDATA)
               wdata_r <= avs_writedata[15:0];
            if (avs_address == PASR_C_CMD && avs_writedata[PASR_CMD_GO]) begin
               busy_r <= 1'b1;
               done_r <= 1'b0;
               we_r   <= avs_writedata[PASR_CMD_WR];
               addr_r <= avs_writedata[4:0];
            end
         end
      end
   end

   assign mgmt.req   = busy_r;
   assign mgmt.we    = we_r;
   assign mgmt.addr  = addr_r;
   assign mgmt.wdata = wdata_r;
endmodule

// >>> core/pasr_phy_regs.sv
// Operation
// - Acknowledge set once partner page received
// - Partner page fields shown read-only
// - Parallel fault latched, cleared on read
// - Page-received latched, cleared on read
// - Partner AN and NP ability, reset zero
// - Local next-page ability bit, default zero
// - Reduced power down disable, default one
// - In-sync and unit power-down status
// - Receive polarity status bit
// - Sampled PHY address field
// - Resolved speed and duplex bits
// - Scrambler and 4B5B bypass controls
// - Force H or 34 test pattern
// - Valid link override
// - Symbol error output enable
// - 100M carrier sense disable
// - Dynamic power-down disable
// - Auto-negotiation loopback control
// - Transmit driver tri-state
// - Force polarity, auto polarity disable
// - Squelch test disable, extended squelch
// - Register 18, expansion high bits zero
//
// Register access over Avalon-MM was decided locally.
module pasr_phy_regs
   import pasr_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   pasr_if.dev              mgmt,
   input  wire logic        page_rx_evt,
   input  wire logic [15:0] lp_page,
   input  wire logic        pd_fault_evt,
   input  wire logic        lp_an_able,
   input  wire logic        lp_np_able,
   input  wire logic        local_np_able,
   input  wire logic        rx_in_sync,
   input  wire logic        pd_100,
   input  wire logic        pd_10,
   input  wire logic        rx_pol_rev,
   input  wire logic [4:0]  phy_addr,
   input  wire logic        an_speed_100,
   input  wire logic        an_full_duplex,
   output logic             rpd_disable,
   output logic [15:0]      special_ctl
);
   logic [15:0] lp_page_r;
   logic        ack_r;
   logic        pdf_r;
   logic        pr_r;
   logic        lpan_r;
   logic        lpnp_r;
   logic [3:0]  sc_wr_r;
   logic [15:0] spec_r;
   logic [15:0] rdata_r;
   logic [15:0] rdata_nxt;
   logic [15:0] partner_view;
   logic [15:0] expand_view;
   logic [15:0] statctl_view;
   logic        ack_out_r;
   logic        rd_go;
   logic        wr_go;
   logic        sel_expand;
   logic        sel_statctl;
   logic        sel_specctl;
   logic        exp_rd;
   logic        sc_we;
   logic        spec_we;

   // Taken once; a standing ack blocks a second take
   assign rd_go       = mgmt.req && !mgmt.we && !ack_out_r;
   assign wr_go       = mgmt.req && mgmt.we && !ack_out_r;

   // Register decode
   assign sel_expand  = (mgmt.addr == PASR_EXPAND_OFS);
   assign sel_statctl = (mgmt.addr == PASR_STATCTL_OFS);
   assign sel_specctl = (mgmt.addr == PASR_SPECCTL_OFS);
   assign exp_rd      = rd_go && sel_expand;
   // writes reach only the writable fields
   assign sc_we       = wr_go && sel_statctl;
   assign spec_we     = wr_go && sel_specctl;

   always_ff @(posedge clk) begin
      if (rst) begin
         lp_page_r <= 16'h0000;
         ack_r     <= 1'b0;
      end else if (page_rx_evt) begin
         lp_page_r <= lp_page;
         ack_r     <= 1'b1;
      end
   end

   // fault latched high, set wins over read clear
   always_ff @(posedge clk) begin
      if (rst)
         pdf_r <= 1'b0;
      else if (pd_fault_evt)
         pdf_r <= 1'b1;
      else if (exp_rd)
         pdf_r <= 1'b0;
   end

   // page received latched high, set wins
   always_ff @(posedge clk) begin
      if (rst)
         pr_r <= 1'b0;
      else if (page_rx_evt)
         pr_r <= 1'b1;
      else if (exp_rd)
         pr_r <= 1'b0;
   end

   // partner AN ability, zero after reset
   always_ff @(posedge clk) begin
      if (rst)
         lpan_r <= 1'b0;
      else
         lpan_r <= lp_an_able;
   end

   // partner next-page ability, zero after reset
   always_ff @(posedge clk) begin
      if (rst)
         lpnp_r <= 1'b0;
      else
         lpnp_r <= lp_np_able;
   end

   // only bits 15:12 of status/control are writable
   always_ff @(posedge clk) begin
      if (rst)
         sc_wr_r <= PASR_SC_RST[15:12];
      else if (sc_we)
         sc_wr_r <= mgmt.wdata[15:12];
   end

   always_ff @(posedge clk) begin
      if (rst)
         spec_r <= PASR_SPEC_RST;
      else if (spec_we)
         spec_r <= mgmt.wdata;
   end

   // One-cycle ack, so the host sees an idle cycle
   always_ff @(posedge clk) begin
      if (rst)
         ack_out_r <= 1'b0;
      else
         ack_out_r <= mgmt.req && !ack_out_r;
   end

   // partner fields, acknowledge in bit 14
   always_comb begin
      partner_view              = lp_page_r;
      partner_view[PASR_PA_ACK] = ack_r;
   end

   always_comb begin
      expand_view               = 16'h0000;
      expand_view[PASR_EX_PDF]  = pdf_r;
      expand_view[PASR_EX_LPNP] = lpnp_r;
      expand_view[PASR_EX_NP]   = local_np_able;
      expand_view[PASR_EX_PR]   = pr_r;
      expand_view[PASR_EX_LPAN] = lpan_r;
   end

   always_comb begin
      statctl_view                       = 16'h0000;
      statctl_view[15:12]                = sc_wr_r;
      statctl_view[PASR_SC_INSYNC]       = rx_in_sync;
      statctl_view[PASR_SC_PD100]        = pd_100;
      statctl_view[PASR_SC_PD10]         = pd_10;
      statctl_view[PASR_SC_POL]          = rx_pol_rev;
      statctl_view[PASR_SC_ADDR_LO +: 5] = phy_addr;
      statctl_view[PASR_SC_SPEED]        = an_speed_100;
      statctl_view[PASR_SC_DUPLEX]       = an_full_duplex;
   end

   // Read select; unmapped numbers read zero
   always_comb begin
      rdata_nxt = 16'h0000;
      case (mgmt.addr)
         PASR_PARTNER_OFS: rdata_nxt = partner_view;
         PASR_EXPAND_OFS:  rdata_nxt = expand_view;
         PASR_STATCTL_OFS: rdata_nxt = statctl_view;
         PASR_SPECCTL_OFS: rdata_nxt = spec_r;
         PASR_RSVD18_OFS:  rdata_nxt = 16'h0000;
         default:          rdata_nxt = 16'h0000;
      endcase
   end

   // Read data holds until the next read
   always_ff @(posedge clk) begin
      if (rst)
         rdata_r <= 16'h0000;
      else if (rd_go)
         rdata_r <= rdata_nxt;
   end

   assign mgmt.rdata  = rdata_r;
   assign mgmt.ack    = ack_out_r;
   assign rpd_disable = sc_wr_r[PASR_SC_RPD_DIS - 12];
   assign special_ctl = spec_r;
endmodule

// >>> shared/pasr_if.sv
interface pasr_if;
   import pasr_pkg::*;
   logic               req;
   logic               we;
   logic [PASR_AW-1:0] addr;
   logic [PASR_DW-1:0] wdata;
   logic [PASR_DW-1:0] rdata;
   logic               ack;
   modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
   modport host (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface

// >>> shared/pasr_pkg.sv
package pasr_pkg;
   localparam int          PASR_AW           = 5;
   localparam int          PASR_DW           = 16;
   localparam logic [4:0]  PASR_PARTNER_OFS  = 5'h05;
   localparam logic [4:0]  PASR_EXPAND_OFS   = 5'h06;
   localparam logic [4:0]  PASR_STATCTL_OFS  = 5'h10;
   localparam logic [4:0]  PASR_SPECCTL_OFS  = 5'h11;
   localparam logic [4:0]  PASR_RSVD18_OFS   = 5'h12;
   // Partner ability fields
   localparam int          PASR_PA_NP        = 15;
   localparam int          PASR_PA_ACK       = 14;
   localparam int          PASR_PA_RF        = 13;
   localparam int          PASR_PA_TECH_LO   = 5;
   localparam int          PASR_PA_SEL_LO    = 0;
   // Expansion fields
   localparam int          PASR_EX_PDF       = 4;
   localparam int          PASR_EX_LPNP      = 3;
   localparam int          PASR_EX_NP        = 2;
   localparam int          PASR_EX_PR        = 1;
   localparam int          PASR_EX_LPAN      = 0;
   // Status/control fields
   localparam int          PASR_SC_RPD_DIS   = 13;
   localparam int          PASR_SC_INSYNC    = 11;
   localparam int          PASR_SC_PD100     = 10;
   localparam int          PASR_SC_PD10      = 9;
   localparam int          PASR_SC_POL       = 8;
   localparam int          PASR_SC_ADDR_LO   = 2;
   localparam int          PASR_SC_SPEED     = 1;
   localparam int          PASR_SC_DUPLEX    = 0;
   // Writable mask of status/control: bits 15:12
   localparam logic [15:0] PASR_SC_WR_MASK   = 16'hF000;
   localparam logic [15:0] PASR_SC_RST       = 16'h2000;
   localparam logic [15:0] PASR_SPEC_RST     = 16'h0000;
   // Controller command register offsets (Avalon word addresses)
   localparam logic [2:0]  PASR_C_CMD        = 3'h0;
   localparam logic [2:0]  PASR_C_WDATA      = 3'h1;
   localparam logic [2:0]  PASR_C_RDATA      = 3'h2;
   localparam logic [2:0]  PASR_C_STATUS     = 3'h3;
   localparam int          PASR_CMD_GO       = 31;
   localparam int          PASR_CMD_WR       = 8;
endpackage

// >>> testbench/pasr_chk.sv
module pasr_chk
   import pasr_pkg::*;
(
   input wire logic         clk,
   input wire logic         rst,
   input wire logic         req,
   input wire logic         we,
   input wire logic [4:0]   addr,
   input wire logic [15:0]  wdata,
   input wire logic [15:0]  rdata,
   input wire logic         ack
);
   logic [15:0] spec_r;
   logic [3:0]  sc_r;
   wire         rd_ack = ack && !we;
   // Shadow of written control bits
   always_ff @(posedge clk) begin
      if (rst) spec_r <= PASR_SPEC_RST;
      else if (ack && we && addr == PASR_SPECCTL_OFS) spec_r <= wdata;
   end
   always_ff @(posedge clk) begin
      if (rst) sc_r <= 4'h2;
      else if (ack && we && addr == PASR_STATCTL_OFS) sc_r <= wdata[15:12];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   ack_pulse_a: assert property (ack |=> !ack) else $error("ack longer than one cycle");
   ack_cause_a: assert property (ack |-> $past(req)) else $error("ack without request");
   req_answer_a: assert property (req && !ack |=> ack) else $error("request not answered");
   host_hold_a: assert property (req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata))
      else $error("request changed before ack");
   req_release_a: assert property (ack |=> !req) else $error("request held after ack");
   rsvd_zero_a: assert property (rd_ack && addr == PASR_RSVD18_OFS |-> rdata == 16'h0000)
      else $error("reserved register not zero");
   exp_high_a: assert property (rd_ack && addr == PASR_EXPAND_OFS |-> rdata[15:5] == 11'h000)
      else $error("expansion upper bits not zero");
   spec_match_a: assert property (rd_ack && addr == PASR_SPECCTL_OFS |-> rdata == spec_r)
      else $error("special control readback wrong");
   sc_match_a: assert property (rd_ack && addr == PASR_STATCTL_OFS |-> rdata[15:12] == sc_r)
      else $error("status control writable bits wrong");
   wr_spec_c: cover property (ack && we && addr == PASR_SPECCTL_OFS);
   rd_exp_c: cover property (rd_ack && addr == PASR_EXPAND_OFS && rdata[1]);
   rd_rsvd_c: cover property (rd_ack && addr == PASR_RSVD18_OFS);
endmodule

// >>> testbench/tb_phy_autoneg_status_control_regs.sv
module tb_phy_autoneg_status_control_regs
   import pasr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, avs_read, avs_write, rpd_disable, page_rx_evt, pd_fault_evt;
   logic lp_an_able, lp_np_able, local_np_able, rx_in_sync, pd_100, pd_10, rx_pol_rev;
   logic an_speed_100, an_full_duplex, avs_waitrequest;
   logic [2:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata, t;
   logic [15:0] lp_page, special_ctl, q, v;
   logic [4:0]  phy_addr;
   int          n_mismatch, tests_run;
   pasr_if lnk();
   pasr_mgmt_ctrl u_pasr_mgmt_ctrl(.clk(clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mgmt(lnk));
   pasr_phy_regs u_pasr_phy_regs(.clk(clk), .rst(rst), .mgmt(lnk), .page_rx_evt(page_rx_evt),
      .lp_page(lp_page), .pd_fault_evt(pd_fault_evt), .lp_an_able(lp_an_able),
      .lp_np_able(lp_np_able), .local_np_able(local_np_able), .rx_in_sync(rx_in_sync),
      .pd_100(pd_100), .pd_10(pd_10), .rx_pol_rev(rx_pol_rev), .phy_addr(phy_addr),
      .an_speed_100(an_speed_100), .an_full_duplex(an_full_duplex),
      .rpd_disable(rpd_disable), .special_ctl(special_ctl));
   pasr_chk u_pasr_chk(.clk(clk), .rst(rst), .req(lnk.req), .we(lnk.we), .addr(lnk.addr),
      .wdata(lnk.wdata), .rdata(lnk.rdata), .ack(lnk.ack));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   task close_out();
      $display("compared %0d, mismatched %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task chk(input logic [15:0] g, input logic [15:0] e);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t ns: got %h expected %h", $time, g, e);
      end
   endtask
   task av(input logic w, input logic [2:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      avs_read <= !w;
      avs_write <= w;
      avs_address <= a;
      avs_writedata <= d;
      // Only the watchdog ends a hang
      do begin
         @(posedge clk);
      end while (avs_waitrequest !== 1'b0);
      r = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask
   task mx(input logic w, input logic [4:0] a, input logic [15:0] d, output logic [15:0] r);
      logic [31:0] x;
      av(1'b1, PASR_C_WDATA, {16'h0000, d}, x);
      av(1'b1, PASR_C_CMD, 32'h8000_0000 | (32'(w) << PASR_CMD_WR) | 32'(a), x);
      do begin
         av(1'b0, PASR_C_STATUS, 32'h0000_0000, x);
      end while (x[0] !== 1'b0);
      av(1'b0, PASR_C_RDATA, 32'h0000_0000, x);
      r = x[15:0];
   endtask
   initial begin
      #200000;
      n_mismatch++;
      close_out();
   end
   initial begin
      {rst, pd_100, pd_10} = 3'b111;
      {avs_read, avs_write, page_rx_evt, pd_fault_evt, lp_an_able, lp_np_able} = 0;
      {local_np_able, rx_in_sync, rx_pol_rev, an_speed_100, an_full_duplex} = 0;
      {avs_address, avs_writedata, lp_page, phy_addr} = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      mx(0, PASR_STATCTL_OFS, 0, q); chk(q, 16'h2600);
      av(1'b0, PASR_C_STATUS, 32'h0000_0000, t);
      chk(t[15:0], 16'h0002);
      chk(t[31:16], 16'h0000);
      av(1'b0, PASR_C_CMD, 32'h0000_0000, t);
      chk(t[15:0], 16'h0010);
      chk(t[31:16], 16'h0000);
      for (int i = 0; i < 4; i++) begin
         mx(1, 5'(i == 3 ? 6'h12 : i + 5), 16'hFFFF, q);
         mx(0, 5'(i == 3 ? 6'h12 : i + 5), 16'h0000, q); chk(q, 16'h0000);
      end
      av(1'b0, 3'h7, 32'h0000_0000, t); chk(t[15:0], 16'h0000);
      $display("test reset and read-only done");
      @(posedge clk);
      {rx_in_sync, pd_100, rx_pol_rev, an_speed_100} <= 4'b1011;
      phy_addr <= 5'h15;
      mx(0, PASR_STATCTL_OFS, 0, q); chk(q, 16'h2B56);
      {rx_in_sync, pd_10, rx_pol_rev, an_speed_100, an_full_duplex} <= 5'b00001;
      phy_addr <= 5'h0A;
      mx(0, PASR_STATCTL_OFS, 0, q); chk(q, 16'h2029);
      mx(1, PASR_STATCTL_OFS, 16'hFFFF, q);
      av(1'b0, PASR_C_WDATA, 32'h0000_0000, t);
      chk(t[15:0], 16'hFFFF);
      av(1'b0, PASR_C_CMD, 32'h0000_0000, t);
      chk(t[15:0], 16'h0110);
      mx(0, PASR_STATCTL_OFS, 0, q); chk(q, 16'hF029);
      chk({15'h0000, rpd_disable}, 16'h0001);
      mx(1, PASR_STATCTL_OFS, 16'h0000, q);
      mx(0, PASR_STATCTL_OFS, 0, q); chk(q, 16'h0029);
      chk({15'h0000, rpd_disable}, 16'h0000);
      $display("test status and control done");
      @(posedge clk);
      {lp_an_able, lp_np_able, local_np_able, page_rx_evt, pd_fault_evt} <= 5'b11111;
      lp_page <= 16'hA5E1;
      @(posedge clk);
      {page_rx_evt, pd_fault_evt} <= 2'b00;
      repeat (2) @(posedge clk);
      mx(0, PASR_PARTNER_OFS, 0, q); chk(q, 16'hE5E1);
      mx(0, PASR_EXPAND_OFS, 0, q); chk(q, 16'h001F);
      mx(0, PASR_EXPAND_OFS, 0, q); chk(q, 16'h000D);
      @(posedge clk);
      page_rx_evt <= 1'b1;
      lp_page <= 16'h0001;
      @(posedge clk);
      page_rx_evt <= 1'b0;
      mx(0, PASR_PARTNER_OFS, 0, q); chk(q, 16'h4001);
      $display("test partner page done");
      for (int i = 0; i < 17; i++) begin
         v = (i < 16) ? (16'h0001 << i) : 16'h0000;
         mx(1, PASR_SPECCTL_OFS, v, q);
         chk(special_ctl, v);
         mx(0, PASR_SPECCTL_OFS, 0, q); chk(q, v);
      end
      $display("test special control done");
      close_out();
   end
endmodule
